/* tb/gil_pin_host.sv */
// gil_pin_host: far side of the block, drives the four pins and watches the interrupt pin
// assumes pins change just after a ref_clk edge and are never left floating
`timescale 1ns/1ps
module gil_pin_host (
    // clock
    input wire logic ref_clk,
    // pins
    output logic [3:0] gpio_in,
    // interrupt pin as the host sees it
    input wire logic irq_out_pin,
    input wire logic active_high,
    output logic irq_active
);
    initial gpio_in = 4'h0;
    assign irq_active = (irq_out_pin === active_high);
    // new levels, then edges for sync and debounce to settle
    task automatic drive_pins(input logic [3:0] v, input int settle);
        @(posedge ref_clk);
        gpio_in <= v;
        repeat (settle) @(posedge ref_clk);
    endtask : drive_pins
endmodule : gil_pin_host

/* tb/gil_top_asserts.sv */
// gil_top_asserts: register port and interrupt pin checks for gil_top
// assumes one ref_clk domain and an active-high asynchronous rst
`timescale 1ns/1ps
module gil_top_asserts
    import gil_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // request groups and interrupt pin
    input wire logic converter_irq,
    input wire logic system_irq,
    input wire logic watchdog_irq,
    input wire logic irq_out_pin
);
    logic pol_reg, pol_next;
    logic [7:0] gate_reg, gate_next;
    logic quiet;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // shadow of polarity and group gate
    always_comb begin
        pol_next = pol_reg;
        gate_next = gate_reg;
        if (reg_wr && reg_addr == ADDR_IRQ_PIN_POLARITY) begin
            pol_next = reg_wdata[POLARITY_BIT];
        end
        if (reg_wr && reg_addr == ADDR_IRQ_GROUP_ENABLE) begin
            gate_next = reg_wdata & GROUP_ENABLE_WMASK;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pol_reg <= 1'b0;
            gate_reg <= 8'h00;
        end else begin
            pol_reg <= pol_next;
            gate_reg <= gate_next;
        end
    end
    assign quiet = !gate_reg[GRP_PIN_BIT] && !(gate_reg[GRP_CONVERTER_BIT] && converter_irq)
        && !(gate_reg[GRP_SYSTEM_BIT] && system_irq);
    sequence rd_at(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    chk_unmapped_read: assert property (rd_at(8'h93) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    chk_levels_upper: assert property (rd_at(ADDR_PIN_LEVELS) |=> reg_rdata[7:4] == 4'h0)
        else $error("level register upper bits set");
    chk_flags_upper: assert property ((rd_at(ADDR_RISE_FLAGS) or rd_at(ADDR_FALL_FLAGS)) |=> reg_rdata[7:4] == 4'h0)
        else $error("flag register upper bits set");
    chk_pending_live: assert property (reg_rd && reg_addr == ADDR_IRQ_GROUP_PENDING && $stable(watchdog_irq)
        && $stable(converter_irq)
        && $stable(system_irq) |=> {reg_rdata[7:5], reg_rdata[3:0]} == {2'b00, $past(watchdog_irq), 2'b00,
        $past(converter_irq), $past(system_irq)}) else $error("pending monitor wrong");
    chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved without read");
    chk_pol_read: assert property (rd_at(ADDR_IRQ_PIN_POLARITY) |=> reg_rdata == {7'h00, $past(pol_reg)})
        else $error("polarity readback wrong");
    chk_gate_read: assert property (rd_at(ADDR_IRQ_GROUP_ENABLE) |=> reg_rdata == $past(gate_reg))
        else $error("group enable readback wrong");
    chk_group_drive: assert property ((gate_reg[1] && converter_irq) || (gate_reg[0] && system_irq)
        |=> irq_out_pin == $past(pol_reg)) else $error("interrupt pin not active");
    chk_quiet_inactive: assert property (quiet |=> irq_out_pin == !$past(pol_reg))
        else $error("interrupt pin active while gated");
endmodule : gil_top_asserts

bind gil_top gil_top_asserts u_asserts (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .converter_irq(converter_irq),
    .system_irq(system_irq), .watchdog_irq(watchdog_irq), .irq_out_pin(irq_out_pin));

/* tb/gil_top_test.sv */
// gil_top_test: self-checking bench for gil_top, short debounce and blink periods
// assumes gil_pkg, the checker and the pin host model are compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module gil_top_test;
    import gil_pkg::*;
    localparam int DEB = 2;
    localparam int SET = DEB + 6;
    logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sys_power_on = 1'b0, pol_high = 1'b0;
    logic converter_irq = 1'b0, system_irq = 1'b0, watchdog_irq = 1'b0, irq_active, irq_out_pin;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
    logic [3:0] gpio_in;
    logic [1:0] led_on;
    int n_errors = 0, check_count = 0;
    always #2.5 ref_clk = ~ref_clk;
    gil_top #(.DEB_CYCLES(DEB), .SLOW_PERIOD(400), .FAST_PERIOD(100)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .gpio_in(gpio_in), .sys_power_on(sys_power_on), .otp_led_source(2'b10), .converter_irq(converter_irq),
        .system_irq(system_irq), .watchdog_irq(watchdog_irq), .led_on(led_on), .irq_out_pin(irq_out_pin));
    gil_pin_host u_host (.ref_clk(ref_clk), .gpio_in(gpio_in), .irq_out_pin(irq_out_pin),
        .active_high(pol_high), .irq_active(irq_active));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
        `CHK(nm, e, rv)
    endtask : rc
    task automatic t_reset_values;
        rc(ADDR_RISE_FLAGS, 8'h00, "rise reset");
        rc(ADDR_FALL_FLAGS, 8'h00, "fall reset");
        rc(ADDR_LED_BLINK_CONTROL, 8'h40, "led control reset");
        rc(ADDR_IRQ_PIN_POLARITY, 8'h00, "polarity reset");
        rc(ADDR_IRQ_GROUP_ENABLE, 8'h00, "group enable reset");
        wr(ADDR_IRQ_GROUP_PENDING, 8'hff);
        rc(ADDR_IRQ_GROUP_PENDING, 8'h00, "pending reset");
        rc(ADDR_PIN_IRQ_ENABLE, 8'h00, "pin enable reset");
        rc(ADDR_EDGE_TYPE, 8'h00, "type reset");
        rc(8'h93, 8'h00, "unmapped read");
        $display("test reset_values done");
    endtask : t_reset_values
    task automatic t_detect_types;
        wr(ADDR_EDGE_TYPE, 8'he4);
        u_host.drive_pins(4'hf, SET);
        rc(ADDR_PIN_LEVELS, 8'h0f, "levels high");
        rc(ADDR_RISE_FLAGS, 8'h0b, "rise after up");
        rc(ADDR_FALL_FLAGS, 8'h00, "fall after up");
        wr(ADDR_RISE_FLAGS, 8'h00);
        rc(ADDR_RISE_FLAGS, 8'h01, "level flag held");
        u_host.drive_pins(4'h0, SET);
        rc(ADDR_PIN_LEVELS, 8'h00, "levels low");
        rc(ADDR_FALL_FLAGS, 8'h0c, "fall after down");
        wr(ADDR_FALL_FLAGS, 8'hfb);
        rc(ADDR_FALL_FLAGS, 8'h08, "fall partial clear");
        wr(ADDR_RISE_FLAGS, 8'h0e);
        rc(ADDR_RISE_FLAGS, 8'h00, "level flag clear");
        wr(ADDR_FALL_FLAGS, 8'hff);
        rc(ADDR_FALL_FLAGS, 8'h08, "fall write one");
        wr(ADDR_RISE_FLAGS, 8'hff);
        rc(ADDR_RISE_FLAGS, 8'h00, "rise write one");
        wr(ADDR_FALL_FLAGS, 8'h00);
        rc(ADDR_FALL_FLAGS, 8'h00, "fall clear");
        $display("test detect_types done");
    endtask : t_detect_types
    task automatic t_irq_path;
        logic [7:0] gate[3] = '{8'h02, 8'h01, 8'h00};
        logic [7:0] pend[3] = '{8'h02, 8'h01, 8'h20};
        wr(ADDR_EDGE_TYPE, 8'h00);
        wr(ADDR_PIN_IRQ_ENABLE, 8'h01);
        wr(ADDR_IRQ_GROUP_ENABLE, 8'h10);
        u_host.drive_pins(4'h2, SET);
        rc(ADDR_IRQ_GROUP_PENDING, 8'h00, "disabled pin pending");
        `CHK("irq idle", 1'b0, irq_active)
        u_host.drive_pins(4'h3, SET);
        rc(ADDR_IRQ_GROUP_PENDING, 8'h10, "pin group pending");
        `CHK("irq low active", 1'b1, irq_active)
        wr(ADDR_IRQ_PIN_POLARITY, 8'h01);
        pol_high <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK("irq high active", 1'b1, irq_active)
        wr(ADDR_IRQ_GROUP_ENABLE, 8'h00);
        rc(ADDR_IRQ_GROUP_PENDING, 8'h10, "pending ungated");
        `CHK("irq gated", 1'b0, irq_active)
        u_host.drive_pins(4'h0, SET);
        wr(ADDR_RISE_FLAGS, 8'h00);
        rc(ADDR_IRQ_GROUP_PENDING, 8'h00, "pending cleared");
        for (int g = 0; g < 3; g++) begin
            wr(ADDR_IRQ_GROUP_ENABLE, gate[g]);
            converter_irq <= (g == 0);
            system_irq <= (g == 1);
            watchdog_irq <= (g == 2);
            rc(ADDR_IRQ_GROUP_PENDING, pend[g], "group pending");
            `CHK("group drive", g < 2, irq_active)
            @(posedge ref_clk);
            converter_irq <= 1'b0;
            system_irq <= 1'b0;
            watchdog_irq <= 1'b0;
        end
        $display("test irq_path done");
    endtask : t_irq_path
    task automatic t_led;
        int exp_lit[4] = '{0, 100, 100, 400};
        int lit;
        @(posedge ref_clk);
        sys_power_on <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK("led follows power on", 1'b1, led_on[0])
        sys_power_on <= 1'b0;
        repeat (3) @(posedge ref_clk);
        `CHK("led follows power off", 1'b0, led_on[0])
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_LED_BLINK_CONTROL, 8'h40 | 8'(p << 4));
            repeat (2) @(posedge ref_clk);
            lit = 0;
            repeat (400) begin
                @(posedge ref_clk);
                if (led_on[1] === 1'b1) lit++;
            end
            `CHK("led lit cycles", exp_lit[p], lit)
        end
        wr(ADDR_LED_BLINK_CONTROL, 8'hff);
        rc(ADDR_LED_BLINK_CONTROL, 8'h77, "led control mask");
        `CHK("both leds lit", 2'b11, led_on)
        $display("test led done");
    endtask : t_led
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_reset_values();
        t_detect_types();
        t_irq_path();
        t_led();
        report_and_stop();
    end
    // watchdog, run needs about 1800 cycles
    initial begin
        #50us;
        n_errors++;
        report_and_stop();
    end
endmodule : gil_top_test

/* verilog/gil_pkg.sv */
// gil_pkg: register map, field positions, reset values, encodings and timing counts
// for the pin interrupt, level monitor, indicator drive and interrupt output block.
// assumes a single 200 MHz clock domain.
package gil_pkg;

    // port geometry
    localparam int PIN_COUNT = 4;
    localparam int LED_COUNT = 2;

    // register offsets
    localparam logic [7:0] ADDR_EDGE_TYPE = 8'h92;
    localparam logic [7:0] ADDR_PIN_IRQ_ENABLE = 8'h94;
    localparam logic [7:0] ADDR_RISE_FLAGS = 8'h95;
    localparam logic [7:0] ADDR_FALL_FLAGS = 8'h96;
    localparam logic [7:0] ADDR_PIN_LEVELS = 8'h97;
    localparam logic [7:0] ADDR_LED_BLINK_CONTROL = 8'h98;
    localparam logic [7:0] ADDR_IRQ_PIN_POLARITY = 8'h9c;
    localparam logic [7:0] ADDR_IRQ_GROUP_ENABLE = 8'h9d;
    localparam logic [7:0] ADDR_IRQ_GROUP_PENDING = 8'h9e;

    // writable bits of each control register
    localparam logic [7:0] EDGE_TYPE_WMASK = 8'hff;
    localparam logic [7:0] PIN_IRQ_ENABLE_WMASK = 8'h0f;
    localparam logic [7:0] LED_BLINK_WMASK = 8'h77;
    localparam logic [7:0] POLARITY_WMASK = 8'h01;
    localparam logic [7:0] GROUP_ENABLE_WMASK = 8'h13;

    // field positions
    localparam int LED1_SOURCE_BIT = 6;
    localparam int LED1_PATTERN_LSB = 4;
    localparam int LED0_SOURCE_BIT = 2;
    localparam int LED0_PATTERN_LSB = 0;
    localparam int POLARITY_BIT = 0;
    localparam int GRP_WATCHDOG_BIT = 5;
    localparam int GRP_PIN_BIT = 4;
    localparam int GRP_CONVERTER_BIT = 1;
    localparam int GRP_SYSTEM_BIT = 0;

    // reset values
    localparam logic [7:0] RST_EDGE_TYPE = 8'h00;
    localparam logic [7:0] RST_PIN_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
    localparam logic [7:0] RST_LED_BLINK = 8'h00;
    localparam logic [7:0] RST_POLARITY = 8'h00;
    localparam logic [7:0] RST_GROUP_ENABLE = 8'h00;
    localparam logic [7:0] RST_READ_DATA = 8'h00;

    // detection type per pin
    typedef enum logic [1:0] {
        DET_LEVEL = 2'b00,
        DET_RISE = 2'b01,
        DET_FALL = 2'b10,
        DET_BOTH = 2'b11
    } gil_det_e;

    // indicator pattern
    typedef enum logic [1:0] {
        LED_OFF = 2'b00,
        LED_SLOW = 2'b01,
        LED_FAST = 2'b10,
        LED_LIT = 2'b11
    } gil_led_e;

    // timing
    localparam longint CLK_HZ = 200_000_000;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int LED_SLOW_HZ = 1;
    localparam int LED_FAST_HZ = 4;
    localparam int LED_ON_PCT = 25;
    localparam int LED_SLOW_PERIOD_CYC = int'(CLK_HZ / LED_SLOW_HZ);
    localparam int LED_FAST_PERIOD_CYC = int'(CLK_HZ / LED_FAST_HZ);
    localparam int DEBOUNCE_NS = 20;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : gil_pkg

/* verilog/gil_top.sv */
// gil_top: pin event capture, pin level monitor, two indicator drivers and the
// polarity-programmable interrupt output stage, behind a byte-wide register port.
// assumes the serial control bus front end issues one-cycle read and write strobes
// on ref_clk; converter, system and watchdog requests come from logic on ref_clk.
//
// Behaviour
// - rising edge of debounced pin sets rise flag in rising or both-edge mode.
// - writing zero clears a rise flag; writing one never sets it.
// - in level mode the active pin request is recorded in the rise flags.
// - clear is ignored while the pin's request signal is still high.
// - falling edge of debounced pin sets fall flag in falling or both-edge mode.
// - writing zero clears a fall flag; writing one has no effect.
// - flag registers hold pin n at bit n in bits 3..0, reset zero.
// - read-only level register shows debounced pin levels, one for high.
// - level bits 3..0 per pin, bits 7..4 read zero.
// - two indicators, 1 and 0, driven from power state or pattern, not pins; source bits 6 and 2, patterns 5-4, 1-0.
// - source bit zero: indicator off when powered off, lit when powered on.
// - source bit one: 00 off, 01 1Hz 25%, 10 4Hz 25%, 11 lit.
// - source bits load from factory settings on the first edge after reset release; patterns reset zero.
// - polarity bit 0 selects interrupt pin active level, resets low-active.
// - group enable bits 4 pin, 1 converter, 0 system gate the interrupt pin.
// - read-only pending monitor: bit 5 watchdog, 4 pin, 1 converter, 0 system.
// - per-pin interrupt enable, pin 0 at bit 0, resets disabled.
// - two-bit detection type per pin: 00 level, 01 rise, 10 fall, 11 both.

`timescale 1ns/1ps

module gil_top
    import gil_pkg::*;
#(
    parameter int DEB_CYCLES = DEBOUNCE_CYC,
    parameter int SLOW_PERIOD = LED_SLOW_PERIOD_CYC,
    parameter int FAST_PERIOD = LED_FAST_PERIOD_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // pins and system state
    input wire logic [PIN_COUNT-1:0] gpio_in,
    input wire logic sys_power_on,
    input wire logic [LED_COUNT-1:0] otp_led_source,
    // other request groups
    input wire logic converter_irq,
    input wire logic system_irq,
    input wire logic watchdog_irq,
    // outputs
    output logic [LED_COUNT-1:0] led_on,
    output logic irq_out_pin
);

    localparam int DEB_W = $clog2(DEB_CYCLES + 1);
    localparam int SLOW_W = $clog2(SLOW_PERIOD);
    localparam int FAST_W = $clog2(FAST_PERIOD);
    localparam int SLOW_ON = SLOW_PERIOD / 100 * LED_ON_PCT;
    localparam int FAST_ON = FAST_PERIOD / 100 * LED_ON_PCT;

    function automatic logic is_rise_mode(input logic [1:0] det);
        is_rise_mode = (det == DET_RISE) || (det == DET_BOTH);
    endfunction : is_rise_mode

    function automatic logic is_fall_mode(input logic [1:0] det);
        is_fall_mode = (det == DET_FALL) || (det == DET_BOTH);
    endfunction : is_fall_mode

    function automatic logic led_pick(input logic src, input logic [1:0] pat, input logic pwr,
                                      input logic slow, input logic fast);
        if (!src) begin
            led_pick = pwr;
        end else begin
            unique case (pat)
                LED_OFF: led_pick = 1'b0;
                LED_SLOW: led_pick = slow;
                LED_FAST: led_pick = fast;
                LED_LIT: led_pick = 1'b1;
            endcase
        end
    endfunction : led_pick

    // per-pin synchroniser, debounce and edge detect
    logic [PIN_COUNT-1:0] pin_level;
    logic [PIN_COUNT-1:0] rise_evt;
    logic [PIN_COUNT-1:0] fall_evt;

    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        logic s1_reg, s1_next, s2_reg, s2_next;
        logic deb_reg, deb_next, prev_reg, prev_next;
        logic [DEB_W-1:0] cnt_reg, cnt_next;

        always_comb begin
            s1_next = gpio_in[i];
            s2_next = s1_reg;
            prev_next = deb_reg;
            deb_next = deb_reg;
            cnt_next = '0;
            if (s2_reg != deb_reg) begin
                if (cnt_reg == DEB_W'(DEB_CYCLES - 1)) begin
                    deb_next = s2_reg;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
        end

        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                s1_reg <= 1'b0;
                s2_reg <= 1'b0;
                deb_reg <= 1'b0;
                prev_reg <= 1'b0;
                cnt_reg <= '0;
            end else begin
                s1_reg <= s1_next;
                s2_reg <= s2_next;
                deb_reg <= deb_next;
                prev_reg <= prev_next;
                cnt_reg <= cnt_next;
            end
        end

        assign pin_level[i] = deb_reg;
        assign rise_evt[i] = deb_reg & ~prev_reg;
        assign fall_evt[i] = ~deb_reg & prev_reg;
    end

    // control registers, flags and read data
    logic [7:0] edge_type_reg, edge_type_next;
    logic [7:0] pin_irq_enable_reg, pin_irq_enable_next;
    logic [7:0] led_blink_control_reg, led_blink_control_next;
    logic [7:0] irq_pin_polarity_reg, irq_pin_polarity_next;
    logic [7:0] irq_group_enable_reg, irq_group_enable_next;
    logic [PIN_COUNT-1:0] rise_event_flags_reg, rise_event_flags_next;
    logic [PIN_COUNT-1:0] fall_event_flags_reg, fall_event_flags_next;
    logic otp_loaded_reg, otp_loaded_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [PIN_COUNT-1:0] rise_set;
    logic [PIN_COUNT-1:0] fall_set;
    logic [PIN_COUNT-1:0] rise_clr;
    logic [PIN_COUNT-1:0] fall_clr;
    logic pin_group_pending;
    logic [7:0] irq_group_pending;

    assign pin_group_pending = |((rise_event_flags_reg | fall_event_flags_reg)
                                 & pin_irq_enable_reg[PIN_COUNT-1:0]);

    always_comb begin
        irq_group_pending = 8'h00;
        irq_group_pending[GRP_WATCHDOG_BIT] = watchdog_irq;
        irq_group_pending[GRP_PIN_BIT] = pin_group_pending;
        irq_group_pending[GRP_CONVERTER_BIT] = converter_irq;
        irq_group_pending[GRP_SYSTEM_BIT] = system_irq;
    end

    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            rise_set[i] = ((edge_type_reg[2*i +: 2] == DET_LEVEL) && pin_level[i])
                          || (is_rise_mode(edge_type_reg[2*i +: 2]) && rise_evt[i]);
            fall_set[i] = is_fall_mode(edge_type_reg[2*i +: 2]) && fall_evt[i];
        end
        rise_clr = (reg_wr && reg_addr == ADDR_RISE_FLAGS) ? ~reg_wdata[PIN_COUNT-1:0] : '0;
        fall_clr = (reg_wr && reg_addr == ADDR_FALL_FLAGS) ? ~reg_wdata[PIN_COUNT-1:0] : '0;
        // a set in the same cycle, or a still-high request, beats the clear
        rise_event_flags_next = (rise_event_flags_reg & ~rise_clr) | rise_set;
        fall_event_flags_next = (fall_event_flags_reg & ~fall_clr) | fall_set;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rise_event_flags_reg <= RST_EVENT_FLAGS[PIN_COUNT-1:0];
            fall_event_flags_reg <= RST_EVENT_FLAGS[PIN_COUNT-1:0];
        end else begin
            rise_event_flags_reg <= rise_event_flags_next;
            fall_event_flags_reg <= fall_event_flags_next;
        end
    end

    // control next values and factory source load
    always_comb begin
        edge_type_next = edge_type_reg;
        pin_irq_enable_next = pin_irq_enable_reg;
        led_blink_control_next = led_blink_control_reg;
        irq_pin_polarity_next = irq_pin_polarity_reg;
        irq_group_enable_next = irq_group_enable_reg;
        otp_loaded_next = 1'b1;
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_EDGE_TYPE: edge_type_next = reg_wdata & EDGE_TYPE_WMASK;
                ADDR_PIN_IRQ_ENABLE: pin_irq_enable_next = reg_wdata & PIN_IRQ_ENABLE_WMASK;
                ADDR_LED_BLINK_CONTROL: led_blink_control_next = reg_wdata & LED_BLINK_WMASK;
                ADDR_IRQ_PIN_POLARITY: irq_pin_polarity_next = reg_wdata & POLARITY_WMASK;
                ADDR_IRQ_GROUP_ENABLE: irq_group_enable_next = reg_wdata & GROUP_ENABLE_WMASK;
                default: ;
            endcase
        end
        // factory source bits land on the first edge after reset release
        if (!otp_loaded_reg) begin
            led_blink_control_next[LED1_SOURCE_BIT] = otp_led_source[1];
            led_blink_control_next[LED0_SOURCE_BIT] = otp_led_source[0];
        end
    end

    // control registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            edge_type_reg <= RST_EDGE_TYPE;
            pin_irq_enable_reg <= RST_PIN_IRQ_ENABLE;
            led_blink_control_reg <= RST_LED_BLINK;
            irq_pin_polarity_reg <= RST_POLARITY;
            irq_group_enable_reg <= RST_GROUP_ENABLE;
            otp_loaded_reg <= 1'b0;
        end else begin
            edge_type_reg <= edge_type_next;
            pin_irq_enable_reg <= pin_irq_enable_next;
            led_blink_control_reg <= led_blink_control_next;
            irq_pin_polarity_reg <= irq_pin_polarity_next;
            irq_group_enable_reg <= irq_group_enable_next;
            otp_loaded_reg <= otp_loaded_next;
        end
    end

    // read data, held until the next read strobe
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_EDGE_TYPE: rdata_next = edge_type_reg;
                ADDR_PIN_IRQ_ENABLE: rdata_next = pin_irq_enable_reg;
                ADDR_RISE_FLAGS: rdata_next = {4'h0, rise_event_flags_reg};
                ADDR_FALL_FLAGS: rdata_next = {4'h0, fall_event_flags_reg};
                ADDR_PIN_LEVELS: rdata_next = {4'h0, pin_level};
                ADDR_LED_BLINK_CONTROL: rdata_next = led_blink_control_reg;
                ADDR_IRQ_PIN_POLARITY: rdata_next = irq_pin_polarity_reg;
                ADDR_IRQ_GROUP_ENABLE: rdata_next = irq_group_enable_reg;
                ADDR_IRQ_GROUP_PENDING: rdata_next = irq_group_pending;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= RST_READ_DATA;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // blink timebases, indicator drive and interrupt pin
    logic [SLOW_W-1:0] slow_cnt_reg, slow_cnt_next;
    logic [FAST_W-1:0] fast_cnt_reg, fast_cnt_next;
    logic [LED_COUNT-1:0] led_reg, led_next;
    logic irq_out_reg, irq_out_next;
    logic slow_phase;
    logic fast_phase;
    logic irq_active;

    assign slow_phase = slow_cnt_reg < SLOW_W'(SLOW_ON);
    assign fast_phase = fast_cnt_reg < FAST_W'(FAST_ON);
    assign irq_active = |(irq_group_pending & irq_group_enable_reg);

    always_comb begin
        slow_cnt_next = (slow_cnt_reg == SLOW_W'(SLOW_PERIOD - 1)) ? '0 : slow_cnt_reg + 1'b1;
        fast_cnt_next = (fast_cnt_reg == FAST_W'(FAST_PERIOD - 1)) ? '0 : fast_cnt_reg + 1'b1;
        led_next[1] = led_pick(led_blink_control_reg[LED1_SOURCE_BIT],
                               led_blink_control_reg[LED1_PATTERN_LSB +: 2],
                               sys_power_on, slow_phase, fast_phase);
        led_next[0] = led_pick(led_blink_control_reg[LED0_SOURCE_BIT],
                               led_blink_control_reg[LED0_PATTERN_LSB +: 2],
                               sys_power_on, slow_phase, fast_phase);
    end

    // interrupt pin, idle at the inverse of the programmed active level
    always_comb begin
        irq_out_next = irq_pin_polarity_reg[POLARITY_BIT] ? irq_active : ~irq_active;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slow_cnt_reg <= '0;
            fast_cnt_reg <= '0;
            led_reg <= '0;
        end else begin
            slow_cnt_reg <= slow_cnt_next;
            fast_cnt_reg <= fast_cnt_next;
            led_reg <= led_next;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_out_reg <= ~RST_POLARITY[POLARITY_BIT];
        end else begin
            irq_out_reg <= irq_out_next;
        end
    end

    assign led_on = led_reg;
    assign irq_out_pin = irq_out_reg;

endmodule : gil_top
